//--- sep_pkg.sv
package sep_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned PROG_TIME_US    = 5000;
  localparam int unsigned PROG_MAX_US     = 10000;
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned PROG_CNT_W      = 19;

  // ------------------------------------------------------------
  // array and buffer geometry
  // ------------------------------------------------------------
  localparam int unsigned WORDS      = 16;
  localparam int unsigned FIFO_W     = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [4:0]  OPC_BITS   = 5'h04;
  localparam logic [4:0]  ADDR_X16   = 5'h04;
  localparam logic [4:0]  ADDR_X8    = 5'h05;
  localparam logic [4:0]  DATA_X16   = 5'h10;
  localparam logic [4:0]  DATA_X8    = 5'h08;
  localparam logic [15:0] ERASED     = 16'hFFFF;

  // ------------------------------------------------------------
  // opcodes (two-bit group, then four-bit specials)
  // ------------------------------------------------------------
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_ERASE  = 2'h3;
  localparam logic [3:0] PROGRAM_ENABLE_CMD  = 4'h3;
  localparam logic [3:0] PROGRAM_DISABLE_CMD = 4'h0;
  localparam logic [3:0] CLEAR_ALL_CMD       = 4'h2;
  localparam logic [3:0] FILL_ALL_CMD        = 4'h1;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_SKIP  = 8'h02,
    ST_START = 8'h04,
    ST_OPC   = 8'h08,
    ST_ADDR  = 8'h10,
    ST_DATA  = 8'h20,
    ST_READ  = 8'h40,
    ST_HOLD  = 8'h80
  } sep_state_e;

  typedef enum logic [1:0] {
    PO_WRITE = 2'h0,
    PO_ERASE = 2'h1,
    PO_CLEAR = 2'h2,
    PO_FILL  = 2'h3
  } sep_prog_e;

  typedef logic [WORDS-1:0][15:0] sep_mem_t;

  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
    logic org;
  } sep_pins_s;

endpackage : sep_pkg

//--- sep_core.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// read-ahead buffer
// ------------------------------------------------------------
module sep_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 8
) (
  input  wire logic         clk,       // clock
  input  wire logic         rst,       // sync reset
  input  wire logic         flush,     // drop contents
  input  wire logic         in_valid,  // push request
  output logic              in_ready,  // room left
  input  wire logic [W-1:0] in_data,   // push word
  output logic              out_valid, // word present
  input  wire logic         out_ready, // pop request
  output logic [W-1:0]      out_data   // head word
);
  localparam int unsigned AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } sep_fifo_s;

  sep_fifo_s r;
  sep_fifo_s n;
  logic      push;
  logic      pop;

  assign in_ready  = (r.cnt != FULL);
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];

  always_comb begin
    n    = r;
    push = in_valid & in_ready;
    pop  = out_ready & out_valid;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp        = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (rst || flush) begin
      n = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end
endmodule : sep_fifo

module sep_core
  import sep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  input  wire logic CLK,          // 40 MHz clock
  input  wire logic RESET,        // sync reset, high
  input  wire logic CS,           // chip select pin
  input  wire logic SK,           // serial clock pin
  input  wire logic DI,           // serial data in pin
  input  wire logic ORG,          // 1 = x16, 0 = x8
  output logic      DO,           // serial data out
  output logic      DO_OE,        // data out enable
  output logic      BUSY,         // programming running
  output logic      PROG_ENABLED  // programming allowed
);
  localparam logic [PROG_CNT_W-1:0] LAST_CNT = PROG_CNT_W'(PROG_CYCLES - 1);

  typedef struct packed {
    sep_pins_s             s1;
    sep_pins_s             s2;
    logic                  sk_d;
    sep_state_e            st;
    logic                  org;
    logic [3:0]            opc;
    logic [4:0]            addr;
    logic [15:0]           data;
    logic [4:0]            bcnt;
    logic [15:0]           sh;
    logic [4:0]            ptr;
    logic                  rd_bit;
    logic                  arm;
    sep_prog_e             p_op;
    logic [4:0]            p_addr;
    logic [15:0]           p_data;
    logic                  p_org;
    logic                  busy;
    logic [PROG_CNT_W-1:0] cnt;
    logic                  en;
    logic                  stat;
    logic                  do_bit;
    logic                  do_oe;
    sep_mem_t              mem;
  } sep_core_s;

  sep_core_s   r;
  sep_core_s   n;
  logic        sk_rise;
  logic        sel;
  logic        f_ivalid;
  logic        f_iready;
  logic [15:0] f_idata;
  logic        f_ovalid;
  logic        f_oready;
  logic [15:0] f_odata;
  logic        f_flush;

  // ------------------------------------------------------------
  // array access helpers
  // ------------------------------------------------------------
  // even byte sits in the low half of its word
  function automatic logic [15:0] unit_get(sep_mem_t m, logic [4:0] a, logic o);
    logic [15:0] w;
    w = m[a[4:1]];
    if (o) begin
      unit_get = m[a[3:0]];
    end else begin
      unit_get = {(a[0] ? w[15:8] : w[7:0]), 8'h00};
    end
  endfunction : unit_get

  function automatic sep_mem_t unit_put(sep_mem_t m, logic [4:0] a, logic o, logic [15:0] d);
    sep_mem_t t;
    t = m;
    if (o) begin
      t[a[3:0]] = d;
    end else if (a[0]) begin
      t[a[4:1]][15:8] = d[7:0];
    end else begin
      t[a[4:1]][7:0] = d[7:0];
    end
    unit_put = t;
  endfunction : unit_put

  function automatic logic [4:0] ptr_next(logic [4:0] p, logic o);
    ptr_next = o ? {1'b0, p[3:0] + 4'h1} : p + 5'h01;
  endfunction : ptr_next

  function automatic logic [4:0] unit_bits(logic o);
    unit_bits = o ? DATA_X16 : DATA_X8;
  endfunction : unit_bits

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n        = r;
    f_ivalid = 1'b0;
    f_idata  = '0;
    f_oready = 1'b0;
    f_flush  = 1'b0;
    n.s1     = '{cs: CS, sk: SK, di: DI, org: ORG};
    n.s2     = r.s1;
    n.sk_d   = r.s2.sk;
    sk_rise  = r.s2.sk & ~r.sk_d;
    sel      = r.s2.cs;

    // self-timed cycle on CLK only, so a stopped host clock is harmless
    if (r.busy) begin
      if (r.cnt == LAST_CNT) begin
        n.busy = 1'b0;
        unique case (r.p_op)
          PO_WRITE: n.mem = unit_put(r.mem, r.p_addr, r.p_org, r.p_data);
          PO_ERASE: n.mem = unit_put(r.mem, r.p_addr, r.p_org, ERASED);
          PO_CLEAR: n.mem = {WORDS{ERASED}};
          PO_FILL:  n.mem = {WORDS{r.p_org ? r.p_data : {2{r.p_data[7:0]}}}};
        endcase
      end else begin
        n.cnt = r.cnt + 1'b1;
      end
    end

    if (!sel) begin
      // falling select launches an armed program cycle
      if (r.arm && !r.busy) begin
        n.busy = 1'b1;
        n.cnt  = '0;
        n.stat = 1'b1;
      end
      n.arm   = 1'b0;
      n.st    = ST_IDLE;
      // a stale read bit must not show on the next select
      n.rd_bit = 1'b0;
      f_flush = 1'b1;
    end else begin
      unique case (r.st)
        ST_IDLE: begin
          n.st     = ST_SKIP;
          n.rd_bit = 1'b0;
        end
        ST_SKIP: begin
          if (sk_rise) begin
            n.st = ST_START;
          end
        end
        ST_START: begin
          // while busy the bus is ignored
          if (sk_rise && r.s2.di && !r.busy) begin
            n.st   = ST_OPC;
            n.bcnt = OPC_BITS - 5'h01;
            n.org  = r.s2.org;
            n.opc  = '0;
            n.addr = '0;
            n.data = '0;
            n.stat = 1'b0;
          end
        end
        ST_OPC: begin
          if (sk_rise) begin
            n.opc  = {r.opc[2:0], r.s2.di};
            n.bcnt = r.bcnt - 5'h01;
            if (r.bcnt == '0 + 5'h00) begin
              n.st   = ST_ADDR;
              n.bcnt = (r.org ? ADDR_X16 : ADDR_X8) - 5'h01;
            end
          end
        end
        ST_ADDR: begin
          if (sk_rise) begin
            n.addr = {r.addr[3:0], r.s2.di};
            n.bcnt = r.bcnt - 5'h01;
            if (r.bcnt == 5'h00) begin
              n.st     = ST_HOLD;
              n.p_addr = n.addr;
              n.p_org  = r.org;
              if (r.opc[3:2] == OP_READ) begin
                n.ptr    = n.addr;
                n.st     = ST_READ;
                n.bcnt   = 5'h00;
                n.rd_bit = 1'b0;
              end else if (r.opc[3:2] == OP_WRITE || r.opc == FILL_ALL_CMD) begin
                n.st   = ST_DATA;
                n.bcnt = unit_bits(r.org) - 5'h01;
                n.p_op = (r.opc[3:2] == OP_WRITE) ? PO_WRITE : PO_FILL;
              end else if (r.opc[3:2] == OP_ERASE) begin
                n.arm  = r.en;
                n.p_op = PO_ERASE;
              end else if (r.opc == CLEAR_ALL_CMD) begin
                n.arm  = r.en;
                n.p_op = PO_CLEAR;
              end else if (r.opc == PROGRAM_ENABLE_CMD) begin
                n.en = 1'b1;
              end else begin
                n.en = 1'b0;
              end
            end
          end
        end
        ST_DATA: begin
          if (sk_rise) begin
            n.data = {r.data[14:0], r.s2.di};
            n.bcnt = r.bcnt - 5'h01;
            if (r.bcnt == 5'h00) begin
              n.p_data = n.data;
              n.arm    = r.en;
              n.st     = ST_HOLD;
            end
          end
        end
        ST_READ: begin
          // read-ahead stalls when the buffer fills
          if (f_iready) begin
            f_ivalid = 1'b1;
            f_idata  = unit_get(r.mem, r.ptr, r.org);
            n.ptr    = ptr_next(r.ptr, r.org);
          end
          if (sk_rise) begin
            if (r.bcnt == 5'h00) begin
              // next unit follows without a second dummy bit
              f_oready = 1'b1;
              n.rd_bit = f_ovalid & f_odata[15];
              n.sh     = {f_odata[14:0], 1'b0};
              n.bcnt   = unit_bits(r.org) - 5'h01;
            end else begin
              n.rd_bit = r.sh[15];
              n.sh     = {r.sh[14:0], 1'b0};
              n.bcnt   = r.bcnt - 5'h01;
            end
          end
        end
        ST_HOLD: begin
          // an extra clock edge before deselect cancels programming
          if (sk_rise) begin
            n.arm = 1'b0;
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end

    n.do_oe = sel;
    if (!sel) begin
      n.do_bit = 1'b0;
    end else if (r.stat && (r.st == ST_SKIP || r.st == ST_START)) begin
      n.do_bit = ~r.busy;
    end else begin
      n.do_bit = r.rd_bit;
    end

    if (RESET) begin
      n      = '0;
      n.st   = ST_IDLE;
      n.mem  = {WORDS{ERASED}};
      f_flush = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    r <= n;
  end

  sep_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst       (RESET),
    .flush     (f_flush),
    .in_valid  (f_ivalid),
    .in_ready  (f_iready),
    .in_data   (f_idata),
    .out_valid (f_ovalid),
    .out_ready (f_oready),
    .out_data  (f_odata)
  );

  assign DO           = r.do_bit;
  assign DO_OE        = r.do_oe;
  assign BUSY         = r.busy;
  assign PROG_ENABLED = r.en;
endmodule : sep_core

//--- sep_core_props.sv
`timescale 1ns/100ps
module sep_core_props
  import sep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 50
) (
  input wire logic CLK,          // clock
  input wire logic RESET,        // sync reset
  input wire logic CS,           // select pin
  input wire logic SK,           // serial clock pin
  input wire logic DI,           // serial data in
  input wire logic ORG,          // width strap
  input wire logic DO,           // serial data out
  input wire logic DO_OE,        // out enable
  input wire logic BUSY,         // programming
  input wire logic PROG_ENABLED  // enable state
);
  int unsigned cnt;

  always_ff @(posedge CLK) begin
    cnt <= (BUSY && !RESET) ? cnt + 1 : 32'h0;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_OE_HIGH: assert property (CS [*4] |-> DO_OE)
    else $error("out enable low while selected");
  AST_OE_LOW: assert property (!CS [*4] |-> !DO_OE)
    else $error("out enable high while deselected");
  AST_BUSY_LEN: assert property ($fell(BUSY) |-> cnt >= PROG_CYCLES && cnt <= PROG_CYCLES + 2)
    else $error("program cycle length wrong");
  AST_BUSY_MAX: assert property (BUSY |-> cnt <= PROG_CYCLES + 2)
    else $error("program cycle overran");
  AST_BUSY_CSLOW: assert property ($rose(BUSY) |-> !$past(CS, 2))
    else $error("program cycle began while selected");
  AST_BUSY_PE: assert property ($rose(BUSY) |-> PROG_ENABLED)
    else $error("program cycle while disabled");
  AST_PE_CS: assert property ($changed(PROG_ENABLED) |-> $past(CS, 3))
    else $error("enable state changed outside a frame");
  AST_DO_EDGE: assert property (
    $changed(DO) && CS && $past(CS, 4) && $past(DO_OE, 2) && !BUSY && !$past(BUSY, 3) |-> $past(SK, 4))
    else $error("data out moved without clock rise");

  CVR_PROG: cover property ($fell(BUSY));
  CVR_PE: cover property ($rose(PROG_ENABLED));
  CVR_OE: cover property ($rose(DO_OE));
endmodule : sep_core_props

bind sep_core sep_core_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.CLK(CLK), .RESET(RESET), .CS(CS),
  .SK(SK), .DI(DI), .ORG(ORG), .DO(DO), .DO_OE(DO_OE), .BUSY(BUSY), .PROG_ENABLED(PROG_ENABLED));

//--- sep_host.sv
`timescale 1ns/100ps
module sep_host
  import sep_pkg::*;
(
  input  wire logic clk,    // bench clock
  input  wire logic do_pin, // device data out
  output logic      cs,     // select
  output logic      sk,     // serial clock
  output logic      di      // serial data
);
  initial begin
    cs = 1'b0;
    sk = 1'b0;
    di = 1'b0;
  end

  // 10-cycle halves keep both clock phases at least 250 ns
  task automatic tick(input logic b);
    di = b;
    repeat (10) @(negedge clk);
    sk = 1'b1;
    repeat (10) @(negedge clk);
    sk = 1'b0;
  endtask : tick

  task automatic send(input logic [31:0] v, input int n);
    cs = 1'b1;
    tick(1'b0);
    tick(1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      tick(v[i]);
    end
  endtask : send

  // di toggles where the device ignores it
  task automatic bit_in(output logic b);
    tick(~di);
    b = do_pin;
  endtask : bit_in

  task automatic sel();
    cs = 1'b1;
  endtask : sel

  task automatic stop();
    cs = 1'b0;
    repeat (12) @(negedge clk);
  endtask : stop
endmodule : sep_host

//--- testbench.sv
`timescale 1ns/100ps
module testbench
  import sep_pkg::*;
;
  localparam int unsigned PC = 50;
  logic        CLK, RESET, ORG, cs, sk, di, DO, DO_OE, BUSY, PROG_ENABLED;
  logic [15:0] ref_mem [16];
  int          bad_count, samples_checked;

  sep_core #(.PROG_CYCLES(PC)) dut (.CLK(CLK), .RESET(RESET), .CS(cs), .SK(sk), .DI(di), .ORG(ORG),
    .DO(DO), .DO_OE(DO_OE), .BUSY(BUSY), .PROG_ENABLED(PROG_ENABLED));
  sep_host host (.clk(CLK), .do_pin(DO), .cs(cs), .sk(sk), .di(di));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ----
  // frame helpers
  // ----
  task automatic cmd(input logic [3:0] op, input logic [4:0] a, input logic [15:0] d, input logic go);
    int na, nd, k;
    logic [15:0] v;
    na = ORG ? 4 : 5;
    nd = (op[3:2] == OP_WRITE || op == FILL_ALL_CMD) ? (ORG ? 16 : 8) : 0;
    host.send(({28'h0, op} << (na + nd)) | ({27'h0, a} << nd) | {16'h0, d}, 4 + na + nd);
    host.stop();
    chk("busy", {15'h0, go}, {15'h0, BUSY});
    if (go) begin
      host.sel();
      repeat (6) @(negedge CLK);
      chk("busy status", 16'h0, {15'h0, DO});
      k = 0;
      while (BUSY === 1'b1 && k < PC + 20) begin
        @(negedge CLK);
        k++;
      end
      // 18 negedges lie between the select fall and the start of the loop
      chk("busy span", 16'h1, {15'h0, (k + 18 >= PC) && (k + 18 <= PC + 4)});
      repeat (6) @(negedge CLK);
      chk("ready status", 16'h1, {15'h0, DO});
      host.stop();
      v = ORG ? d : {d[7:0], d[7:0]};
      if (op[3:2] == OP_ERASE || op == CLEAR_ALL_CMD) v = ERASED;
      for (int i = 0; i < 16; i++) begin
        if (op[3:2] == 2'h0) ref_mem[i] = v;
        else if (i == (ORG ? a[3:0] : a[4:1])) ref_mem[i] = ORG ? v :
          (a[0] ? {v[15:8], ref_mem[i][7:0]} : {ref_mem[i][15:8], v[7:0]});
      end
    end
  endtask : cmd

  task automatic rd(input logic [4:0] a, input int n);
    logic [15:0] g;
    logic        b;
    logic [4:0]  p;
    host.send(({28'h0, OP_READ, 2'h0} << (ORG ? 4 : 5)) | {27'h0, a}, ORG ? 8 : 9);
    chk("dummy bit", 16'h0, {15'h0, DO});
    chk("out enable", 16'h1, {15'h0, DO_OE});
    p = a;
    repeat (n) begin
      g = 16'h0;
      repeat (ORG ? 16 : 8) begin
        host.bit_in(b);
        g = {g[14:0], b};
      end
      chk("read", ORG ? ref_mem[p[3:0]] : {8'h0, p[0] ? ref_mem[p[4:1]][15:8] : ref_mem[p[4:1]][7:0]}, g);
      p = ORG ? {1'b0, p[3:0] + 4'h1} : p + 5'h1;
    end
    host.stop();
  endtask : rd

  // ----
  // scenarios
  // ----
  task automatic t_locked();
    chk("enabled", 16'h0, {15'h0, PROG_ENABLED});
    chk("out enable", 16'h0, {15'h0, DO_OE});
    cmd({OP_WRITE, 2'h0}, 5'h03, 16'h1111, 1'b0);
    rd(5'h03, 1);
    $display("t_locked done");
  endtask : t_locked

  task automatic t_x16();
    cmd(PROGRAM_ENABLE_CMD, 5'h00, 16'h0, 1'b0);
    chk("enabled", 16'h1, {15'h0, PROG_ENABLED});
    cmd({OP_WRITE, 2'h0}, 5'h00, 16'hA5C3, 1'b1);
    cmd({OP_WRITE, 2'h0}, 5'h0F, 16'h1234, 1'b1);
    rd(5'h0F, 3);
    $display("t_x16 done");
  endtask : t_x16

  task automatic t_x8();
    ORG = 1'b0;
    cmd({OP_WRITE, 2'h0}, 5'h01, 16'h005A, 1'b1);
    rd(5'h1F, 3);
    ORG = 1'b1;
    $display("t_x8 done");
  endtask : t_x8

  task automatic t_bulk();
    cmd(FILL_ALL_CMD, 5'h00, 16'h0F0F, 1'b1);
    cmd({OP_ERASE, 2'h0}, 5'h02, 16'h0, 1'b1);
    rd(5'h01, 2);
    cmd(CLEAR_ALL_CMD, 5'h00, 16'h0, 1'b1);
    rd(5'h07, 1);
    cmd(PROGRAM_DISABLE_CMD, 5'h00, 16'h0, 1'b0);
    chk("enabled", 16'h0, {15'h0, PROG_ENABLED});
    cmd({OP_WRITE, 2'h0}, 5'h04, 16'h7777, 1'b0);
    rd(5'h04, 1);
    $display("t_bulk done");
  endtask : t_bulk

  // slow reader keeps the read-ahead full and stalled, and the stream wraps past the top
  task automatic t_fifo();
    logic [15:0] g;
    logic        b;
    host.send(({28'h0, OP_READ, 2'h0} << 4), 8);
    chk("stream dummy", 16'h0, {15'h0, DO});
    for (int w = 0; w < 18; w++) begin
      g = 16'h0;
      repeat (16) begin
        host.bit_in(b);
        g = {g[14:0], b};
      end
      chk("stream word", ref_mem[w % 16], g);
    end
    chk("stream enable", 16'h1, {15'h0, DO_OE});
    host.stop();
    chk("stream release", 16'h0, {15'h0, DO_OE});
    $display("t_fifo done");
  endtask : t_fifo

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  initial begin
    repeat (100000) @(posedge CLK);
    bad_count++;
    results();
  end

  initial begin
    RESET = 1'b1;
    ORG = 1'b1;
    for (int i = 0; i < 16; i++) ref_mem[i] = ERASED;
    repeat (3) @(negedge CLK);
    RESET = 1'b0;
    repeat (6) @(negedge CLK);
    t_locked();
    t_x16();
    t_x8();
    t_fifo();
    t_bulk();
    results();
  end
endmodule : testbench
